// ==== rtl/pad_decoder.sv ====
`timescale 1ns/100ps
// Purpose: Top-level peripheral address decoder with registered selects
// Assumes: Core issues addr/valid/write on mclk; one cycle decode latency
// Notes: Data passes through registered, byte order untouched (little-endian)
module pad_decoder
    import pad_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic [PAD_AW-1:0] req_addr,
    input wire logic req_write,
    input wire logic [PAD_DW-1:0] req_wdata,
    input wire logic [3:0] req_be,
    output logic ahb_sel_q,
    output logic [PAD_NSLOT-1:0] ahb_slot_sel_q,
    output logic irqc_sel_q,
    output logic slow_sel_q,
    output logic [PAD_NSLOT-1:0] slow_slot_sel_q,
    output logic local_sel_q,
    output logic unmapped_q,
    output logic [PAD_AW-1:0] fwd_addr_q,
    output logic fwd_write_q,
    output logic [PAD_DW-1:0] fwd_wdata_q,
    output logic [3:0] fwd_be_q
);
    // ****************************************
    // Region decode
    // ****************************************
    pad_sel_if ahb_if ();
    pad_sel_if slow_if ();

    pad_region_dec #(.BASE(PAD_AHB_BASE)) u_ahb_dec (
        .addr(req_addr),
        .valid(req_valid),
        .sel(ahb_if.src)
    );
    pad_region_dec #(.BASE(PAD_SLOW_BASE)) u_slow_dec (
        .addr(req_addr),
        .valid(req_valid),
        .sel(slow_if.src)
    );

    logic local_hit;
    logic irqc_hit;
    logic unmapped_hit;
    logic [PAD_NSLOT-1:0] ahb_slot_d;
    logic [PAD_NSLOT-1:0] slow_slot_d;

    // Memory space below the peripheral area goes out on the local bus
    assign local_hit = req_valid && (req_addr[PAD_AW-1:PAD_AW-4] < PAD_LOCAL_TOP);
    // The interrupt controller sits in the top fast bus slot, one of 128 decoded there
    assign irqc_hit = ahb_if.hit && (ahb_if.slot == PAD_IRQC_SLOT);
    // A valid access that no region claims is flagged and routed nowhere
    assign unmapped_hit = req_valid && !ahb_if.hit && !slow_if.hit && !local_hit;

    always_comb
    begin
        ahb_slot_d = '0;
        slow_slot_d = '0;
        if (ahb_if.hit)
        begin
            ahb_slot_d[ahb_if.slot] = 1'b1;
        end
        if (slow_if.hit)
        begin
            slow_slot_d[slow_if.slot] = 1'b1;
        end
    end

    // ****************************************
    // Registered fast bus selects
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ahb_sel_q <= 1'b0;
            ahb_slot_sel_q <= '0;
            irqc_sel_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ahb_sel_q <= ahb_if.hit;
            ahb_slot_sel_q <= ahb_slot_d;
            irqc_sel_q <= irqc_hit;
        end
    end

    // ****************************************
    // Registered slow bus selects
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slow_sel_q <= 1'b0;
            slow_slot_sel_q <= '0;
        end
        else if (clk_en)
        begin
            slow_sel_q <= slow_if.hit;
            slow_slot_sel_q <= slow_slot_d;
        end
    end

    // ****************************************
    // Registered local bus and unmapped flags
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            local_sel_q <= 1'b0;
            unmapped_q <= 1'b0;
        end
        else if (clk_en)
        begin
            local_sel_q <= local_hit;
            unmapped_q <= unmapped_hit;
        end
    end

    // ****************************************
    // Forwarded access
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd_addr_q <= '0;
            fwd_write_q <= 1'b0;
            fwd_wdata_q <= '0;
            fwd_be_q <= 4'h0;
        end
        else if (clk_en)
        begin
            fwd_addr_q <= req_addr;
            fwd_write_q <= req_valid && req_write;
            // Lane 0 carries the lowest byte address, no swapping
            fwd_wdata_q <= req_wdata;
            fwd_be_q <= req_valid ? req_be : 4'h0;
        end
    end

    // ****************************************
    // Checks on the fast bus region
    // ****************************************
    a_ahb_top_region: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_AHB_BASE) |=> ahb_sel_q)
        else $error("top region access not selected");

    a_ahb_onehot_slot: assert property (@(posedge mclk) disable iff (!rst_n)
        ahb_sel_q == (ahb_slot_sel_q != '0) && $onehot0(ahb_slot_sel_q))
        else $error("fast slot select not one-hot");

    a_ahb_slot_index: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_AHB_BASE)
        |=> ahb_slot_sel_q[$past(req_addr[PAD_REGION_BITS-1:PAD_SLOT_BITS])])
        else $error("wrong fast slot selected");

    a_ahb_region_only: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && !(req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_AHB_BASE)) |=> !ahb_sel_q)
        else $error("fast region selected outside its range");

    a_irqc_only_fast: assert property (@(posedge mclk) disable iff (!rst_n)
        irqc_sel_q == ahb_slot_sel_q[PAD_IRQC_SLOT])
        else $error("interrupt controller select mismatch");

    a_irqc_top_slot: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_SLOT_BITS] == {PAD_AHB_BASE, PAD_IRQC_SLOT}) |=> irqc_sel_q)
        else $error("interrupt controller slot not selected");

    // ****************************************
    // Checks on the slow bus region
    // ****************************************
    a_slow_region_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_SLOW_BASE)
        |=> slow_sel_q && !ahb_sel_q)
        else $error("slow region access not selected");

    a_slow_onehot_slot: assert property (@(posedge mclk) disable iff (!rst_n)
        slow_sel_q == (slow_slot_sel_q != '0) && $onehot0(slow_slot_sel_q))
        else $error("slow slot select not one-hot");

    a_slow_slot_index: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_SLOW_BASE)
        |=> slow_slot_sel_q[$past(req_addr[PAD_REGION_BITS-1:PAD_SLOT_BITS])])
        else $error("wrong slow slot selected");

    a_slow_region_only: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && !(req_valid && (req_addr[PAD_AW-1:PAD_REGION_BITS] == PAD_SLOW_BASE)) |=> !slow_sel_q)
        else $error("slow region selected outside its range");

    a_bridge_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        slow_sel_q |-> fwd_addr_q[PAD_AW-1:PAD_REGION_BITS] == PAD_SLOW_BASE)
        else $error("bridge passed wrong address");

    // ****************************************
    // Checks on local bus, data lanes and unmapped space
    // ****************************************
    a_local_region: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_AW-4] < PAD_LOCAL_TOP) |=> local_sel_q)
        else $error("memory access not sent to local bus");

    a_local_not_fast: assert property (@(posedge mclk) disable iff (!rst_n)
        local_sel_q |-> !ahb_sel_q && !slow_sel_q)
        else $error("memory access reached peripheral bus");

    a_data_order: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en |=> fwd_wdata_q == $past(req_wdata))
        else $error("byte lane order changed");

    a_lane_enables: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en |=> fwd_be_q == ($past(req_valid) ? $past(req_be) : 4'h0))
        else $error("byte enables not passed per lane");

    a_unmapped_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        clk_en && req_valid && (req_addr[PAD_AW-1:PAD_AW-4] >= PAD_LOCAL_TOP)
        && (req_addr[PAD_AW-1:PAD_REGION_BITS] != PAD_AHB_BASE)
        && (req_addr[PAD_AW-1:PAD_REGION_BITS] != PAD_SLOW_BASE) |=> unmapped_q)
        else $error("unmapped access not flagged");

    a_unmapped_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        unmapped_q |-> !ahb_sel_q && !slow_sel_q && !local_sel_q && ahb_slot_sel_q == '0
        && slow_slot_sel_q == '0)
        else $error("select raised for unmapped address");
endmodule : pad_decoder

// ==== rtl/pad_pkg.sv ====
// Purpose: Constants for the peripheral address decoder
// Assumes: 32-bit byte addresses, 200 MHz mclk
// Notes: Slot counts follow from region and slot sizes
package pad_pkg;
    localparam int unsigned PAD_AW = 32;
    localparam int unsigned PAD_DW = 32;
    localparam int unsigned PAD_SLOT_BITS = 14;
    localparam int unsigned PAD_REGION_BITS = 21;
    localparam int unsigned PAD_NSLOT = 128;
    localparam int unsigned PAD_SW = 7;
    localparam logic [10:0] PAD_AHB_BASE = 11'h7FF;
    localparam logic [10:0] PAD_SLOW_BASE = 11'h700;
    localparam logic [PAD_SW-1:0] PAD_IRQC_SLOT = 7'h7F;
    localparam logic [3:0] PAD_LOCAL_TOP = 4'hE;
endpackage : pad_pkg

// ==== rtl/pad_sel_if.sv ====
`timescale 1ns/100ps
// Purpose: Carries one decoded access between decoder stages
// Assumes: Single clock domain
// Notes: None
interface pad_sel_if;
    import pad_pkg::*;
    logic hit;
    logic [PAD_SW-1:0] slot;
    modport src (output hit, output slot);
    modport dst (input hit, input slot);
endinterface : pad_sel_if

// ==== rtl/pad_region_dec.sv ====
`timescale 1ns/100ps
// Purpose: Region match and slot index extraction for one peripheral region
// Assumes: Combinational, address stable for the cycle
// Notes: Instantiated once per region
module pad_region_dec
    import pad_pkg::*;
#(
    parameter logic [10:0] BASE = 11'h000
)
(
    input wire logic [PAD_AW-1:0] addr,
    input wire logic valid,
    pad_sel_if.src sel
);
    assign sel.hit = valid && (addr[PAD_AW-1:PAD_REGION_BITS] == BASE);
    assign sel.slot = addr[PAD_REGION_BITS-1:PAD_SLOT_BITS];
endmodule : pad_region_dec

// ==== tb/pad_core_model.sv ====
// Purpose: Core model that issues one access per call
// Assumes: Requests driven on falling mclk
// Notes: Released lines show inverted values
`timescale 1ns/100ps
module pad_core_model
    import pad_pkg::*;
(
    input wire logic mclk,
    output logic req_valid,
    output logic [PAD_AW-1:0] req_addr,
    output logic req_write,
    output logic [PAD_DW-1:0] req_wdata,
    output logic [3:0] req_be
);
    initial
    begin
        req_valid = 1'b0;
        req_addr = 32'h0;
        req_write = 1'b0;
        req_wdata = 32'h0;
        req_be = 4'h0;
    end

    // Lane 0 of wdata and be bit 0 belong to the lowest byte address
    task automatic access(input logic [PAD_AW-1:0] a, input logic w, input logic [PAD_DW-1:0] d,
                          input logic [3:0] be);
        @(negedge mclk);
        req_valid = 1'b1;
        req_addr = a;
        req_write = w;
        req_wdata = d;
        req_be = be;
        @(negedge mclk);
        req_valid = 1'b0;
        req_addr = ~a;
        req_write = ~w;
        req_wdata = ~d;
        req_be = ~be;
    endtask : access
endmodule : pad_core_model

// ==== tb/tb_peripheral_address_decoder.sv ====
// Purpose: Self-checking bench for the address decoder
// Assumes: One cycle decode latency
// Notes: Checks run after the capturing edge
`timescale 1ns/100ps
module tb_peripheral_address_decoder;
    import pad_pkg::*;
    logic mclk, rst_n, clk_en, rv, rw;
    logic [31:0] ra, rd;
    logic [3:0] rb;
    logic ahb, irq, slw, loc, unm, fw;
    logic [127:0] ahs, sls;
    logic [31:0] fa, fd;
    logic [3:0] fb;
    int fails = 0;
    int comparisons = 0;

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    pad_core_model core_u (.mclk(mclk), .req_valid(rv), .req_addr(ra), .req_write(rw), .req_wdata(rd), .req_be(rb));
    pad_decoder dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(rv), .req_addr(ra), .req_write(rw),
        .req_wdata(rd), .req_be(rb), .ahb_sel_q(ahb), .ahb_slot_sel_q(ahs), .irqc_sel_q(irq), .slow_sel_q(slw),
        .slow_slot_sel_q(sls), .local_sel_q(loc), .unmapped_q(unm), .fwd_addr_q(fa), .fwd_write_q(fw),
        .fwd_wdata_q(fd), .fwd_be_q(fb));

    task automatic ck(input string n, input logic [127:0] e, input logic [127:0] s);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : ck

    // Selects as {ahb, irqc, slow, local, unmapped}
    task automatic dec(input logic [31:0] a, input logic [4:0] e, input int s);
        logic [127:0] oh;
        oh = 128'h1 << s;
        core_u.access(a, 1'b0, 32'h0, 4'hF);
        ck("ahb_sel", e[4], ahb);
        ck("ahb_slot", e[4] ? oh : 128'h0, ahs);
        ck("irqc_sel", e[3], irq);
        ck("slow_sel", e[2], slw);
        ck("slow_slot", e[2] ? oh : 128'h0, sls);
        ck("local_sel", e[1], loc);
        ck("unmapped", e[0], unm);
        ck("fwd_addr", a, fa);
        ck("fwd_be", 4'hF, fb);
        ck("fwd_write", 1'b0, fw);
    endtask : dec

    task automatic t_fast;
        dec(32'hFFE00000, 5'h10, 0);
        dec(32'hFFFFBFFC, 5'h10, 126);
        dec(32'hFFFFF000, 5'h18, 127);
    endtask : t_fast

    task automatic t_slow;
        dec(32'hE0000000, 5'h04, 0);
        dec(32'hE0004000, 5'h04, 1);
        dec(32'hE01FFFFF, 5'h04, 127);
    endtask : t_slow

    task automatic t_other;
        dec(32'h40000000, 5'h02, 0);
        dec(32'hDFFFFFFC, 5'h02, 0);
        dec(32'hE0200000, 5'h01, 0);
        dec(32'hFFDFFFFC, 5'h01, 0);
    endtask : t_other

    task automatic t_data;
        core_u.access(32'h40000000, 1'b1, 32'h44332211, 4'h1);
        ck("fwd_wdata", 32'h44332211, fd);
        ck("fwd_be", 4'h1, fb);
        ck("fwd_write", 1'b1, fw);
        clk_en = 1'b0;
        core_u.access(32'hFFFFF000, 1'b0, 32'h0, 4'h3);
        ck("frozen_ahb", 1'b0, ahb);
        ck("frozen_local", 1'b1, loc);
        ck("frozen_wdata", 32'h44332211, fd);
        clk_en = 1'b1;
        @(negedge mclk);
        ck("idle_be", 4'h0, fb);
        ck("idle_write", 1'b0, fw);
        ck("idle_unmapped", 1'b0, unm);
    endtask : t_data

    task automatic t_reset;
        core_u.access(32'hFFFFF000, 1'b0, 32'h0, 4'hF);
        ck("irqc_before_reset", 1'b1, irq);
        rst_n = 1'b0;
        #1;
        ck("reset_irqc", 1'b0, irq);
        ck("reset_ahb_slot", 128'h0, ahs);
        ck("reset_addr", 32'h0, fa);
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        dec(32'hE0004000, 5'h04, 1);
    endtask : t_reset

    task automatic give_verdict;
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_fast();
        t_slow();
        t_other();
        t_data();
        t_reset();
        give_verdict();
    end
endmodule : tb_peripheral_address_decoder
